// [pkg/mas_pkg.sv]
// package: register map, field positions and timing counts for the acquisition sequencer
package mas_pkg;
  localparam int unsigned MAS_RES_BITS = 11;
  localparam int unsigned MAS_REG_BITS = 12;
  localparam int unsigned MAS_SHA_CYCLES = 20;
  localparam int unsigned MAS_CONV_CYCLES = 40;
  localparam int unsigned MAS_REACQ_CYCLES = 20;
  localparam int unsigned MAS_CNT_BITS = 6;

  localparam logic [7:0] MAS_OFF_CTRL = 8'h00;
  localparam logic [7:0] MAS_OFF_STAT = 8'h04;
  localparam logic [7:0] MAS_OFF_MASK = 8'h08;
  localparam logic [7:0] MAS_OFF_PWMPER = 8'h0c;
  localparam logic [7:0] MAS_OFF_RES_U = 8'h10;
  localparam logic [7:0] MAS_OFF_RES_V = 8'h14;
  localparam logic [7:0] MAS_OFF_RES_W = 8'h18;
  localparam logic [7:0] MAS_OFF_RES_AUX = 8'h1c;

  localparam int unsigned MAS_CTRL_AUXSEL_LO = 0;
  localparam int unsigned MAS_CTRL_FULL = 3;
  localparam int unsigned MAS_CTRL_AUXEN = 4;
  localparam int unsigned MAS_CTRL_IRQEN = 7;
  localparam logic [11:0] MAS_CTRL_RST = 12'h000;
  localparam logic [11:0] MAS_CTRL_WMASK = 12'h09b;

  localparam int unsigned MAS_ST_DONE = 0;
  localparam int unsigned MAS_ST_OVERRUN = 1;
  localparam int unsigned MAS_ST_DELAYED = 2;
  localparam int unsigned MAS_ST_BUSY = 8;
  localparam logic [2:0] MAS_MASK_RST = 3'h7;

  localparam logic [11:0] MAS_PWMPER_RST = 12'h800;

  localparam logic [1:0] MAS_CH_U = 2'h0;
  localparam logic [1:0] MAS_CH_V = 2'h1;
  localparam logic [1:0] MAS_CH_W = 2'h2;
  localparam logic [1:0] MAS_CH_AUX = 2'h3;

  localparam logic [1:0] MAS_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] MAS_HTRANS_SEQ = 2'h3;
  localparam logic [2:0] MAS_HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    MAS_IDLE,
    MAS_SAMPLE,
    MAS_CONVERT
  } mas_state_t;
endpackage

// [src/mas_pwm_sync.sv]
// pwm cycle timer that marks the start of each cycle with a one-clock pulse
`timescale 1ns/10ps
`default_nettype none
module mas_pwm_sync
  import mas_pkg::*;
#(
  parameter int unsigned WIDTH = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] period,
  output logic sync_pulse_q
);
  logic [WIDTH-1:0] count_q;

  initial begin
    if (WIDTH < 2 || WIDTH > 16) $error("mas_pwm_sync: WIDTH out of range");
  end

  // a period of zero stops the timer and the pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= '0;
    end else if (period == '0 || count_q >= period - 1'b1) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_pulse_q <= 1'b0;
    end else begin
      sync_pulse_q <= (period != '0) && (count_q == '0);
    end
  end
endmodule
`default_nettype wire

// [src/mas_acq_seq.sv]
// acquisition sequencer: ahb-lite registers, sample/hold and per-channel conversion control
`timescale 1ns/10ps
`default_nettype none
module mas_acq_seq
  import mas_pkg::*;
#(
  parameter int unsigned PWM_WIDTH = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic conversion_start_pin,
  input wire logic [MAS_RES_BITS-1:0] adc_result,
  output logic adc_hold_q,
  output logic adc_convert_q,
  output logic [1:0] adc_chan_q,
  output logic [1:0] aux_sel_q,
  output logic pwm_cycle_sync_pulse,
  output logic irq_n_out_q,
  output logic irq_n_oe_q
);
  initial begin
    if (PWM_WIDTH < 2 || PWM_WIDTH > MAS_REG_BITS) $error("mas_acq_seq: PWM_WIDTH out of range");
  end

  // bus state
  logic [31:0] hrdata_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic rd_stat_q;
  logic addr_phase;
  logic [7:0] a_off;

  // registers
  logic [11:0] ctrl_q;
  logic [2:0] status_q;
  logic [2:0] mask_q;
  logic [PWM_WIDTH-1:0] pwm_per_q;
  logic [MAS_REG_BITS-1:0] result_q [4];

  // sequencer
  mas_state_t state_q;
  logic [MAS_CNT_BITS-1:0] cnt_q;
  logic [MAS_CNT_BITS-1:0] reacq_q;
  logic [1:0] last_chan_q;
  logic start_pend_q;
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic start_edge;
  logic group_done;
  logic conv_last;
  logic launch;
  logic [2:0] stat_set;
  logic stat_clr_rd;
  logic [2:0] stat_clr_wr;

  assign addr_phase = hsel && hready && (htrans == MAS_HTRANS_NONSEQ || htrans == MAS_HTRANS_SEQ);
  assign a_off = haddr[7:0];

  assign hrdata = hrdata_q;

  // zero wait states: reads are looked up during the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= addr_phase && hwrite && (hsize == MAS_HSIZE_WORD) && (haddr[31:8] == '0);
      wr_addr_q <= a_off;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= '0;
    end else if (addr_phase && !hwrite) begin
      hrdata_q <= '0;
      if (haddr[31:8] == '0) begin
        unique case (a_off)
          MAS_OFF_CTRL: hrdata_q[11:0] <= ctrl_q;
          MAS_OFF_STAT: begin
            hrdata_q[2:0] <= status_q;
            hrdata_q[MAS_ST_BUSY] <= (state_q != MAS_IDLE) || start_pend_q;
          end
          MAS_OFF_MASK: hrdata_q[2:0] <= mask_q;
          MAS_OFF_PWMPER: hrdata_q[PWM_WIDTH-1:0] <= pwm_per_q;
          MAS_OFF_RES_U: hrdata_q[11:0] <= result_q[MAS_CH_U];
          MAS_OFF_RES_V: hrdata_q[11:0] <= result_q[MAS_CH_V];
          MAS_OFF_RES_W: hrdata_q[11:0] <= result_q[MAS_CH_W];
          MAS_OFF_RES_AUX: hrdata_q[11:0] <= result_q[MAS_CH_AUX];
          default: hrdata_q <= '0;
        endcase
      end
    end
  end

  // reading status clears the flags the reader has just been shown
  assign stat_clr_rd = addr_phase && !hwrite && (haddr[31:8] == '0) && (a_off == MAS_OFF_STAT);
  assign stat_clr_wr = (wr_pend_q && wr_addr_q == MAS_OFF_STAT) ? hwdata[2:0] : 3'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= MAS_CTRL_RST;
    end else if (wr_pend_q && wr_addr_q == MAS_OFF_CTRL) begin
      ctrl_q <= hwdata[11:0] & MAS_CTRL_WMASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= MAS_MASK_RST;
    end else if (wr_pend_q && wr_addr_q == MAS_OFF_MASK) begin
      mask_q <= hwdata[2:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_per_q <= MAS_PWMPER_RST[PWM_WIDTH-1:0];
    end else if (wr_pend_q && wr_addr_q == MAS_OFF_PWMPER) begin
      pwm_per_q <= hwdata[PWM_WIDTH-1:0];
    end
  end

  // set wins over both read-clear and write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~stat_clr_wr & ~{3{stat_clr_rd}}) | stat_set;
    end
  end

  // start pin: two flops to resynchronise, the third only for the edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= conversion_start_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign start_edge = sync2_q && !sync3_q;

  // a start is only accepted when no group is pending or running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_pend_q <= 1'b0;
    end else if (launch) begin
      start_pend_q <= 1'b0;
    end else if (start_edge && state_q == MAS_IDLE) begin
      start_pend_q <= 1'b1;
    end
  end

  // holds off sampling after reset and after each group end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reacq_q <= MAS_CNT_BITS'(MAS_REACQ_CYCLES);
    end else if (group_done) begin
      reacq_q <= MAS_CNT_BITS'(MAS_REACQ_CYCLES);
    end else if (reacq_q != '0) begin
      reacq_q <= reacq_q - 1'b1;
    end
  end

  assign launch = (state_q == MAS_IDLE) && start_pend_q && (reacq_q == '0);
  assign conv_last = (cnt_q == MAS_CNT_BITS'(MAS_CONV_CYCLES - 1));
  assign group_done = (state_q == MAS_CONVERT) && conv_last && (adc_chan_q == last_chan_q);

  assign stat_set[MAS_ST_DONE] = group_done && ctrl_q[MAS_CTRL_IRQEN];
  assign stat_set[MAS_ST_OVERRUN] = start_edge && (state_q != MAS_IDLE || start_pend_q);
  assign stat_set[MAS_ST_DELAYED] = start_edge && state_q == MAS_IDLE && !start_pend_q && reacq_q > 1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= MAS_IDLE;
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        MAS_IDLE: begin
          cnt_q <= '0;
          if (launch) begin
            state_q <= MAS_SAMPLE;
          end
        end
        MAS_SAMPLE: begin
          if (cnt_q == MAS_CNT_BITS'(MAS_SHA_CYCLES - 1)) begin
            cnt_q <= '0;
            state_q <= MAS_CONVERT;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        MAS_CONVERT: begin
          if (conv_last) begin
            cnt_q <= '0;
            if (adc_chan_q == last_chan_q) begin
              state_q <= MAS_IDLE;
            end
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  // group limits latched at launch so a control write mid-group does no harm
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_chan_q <= MAS_CH_V;
      last_chan_q <= MAS_CH_W;
      aux_sel_q <= '0;
    end else if (launch) begin
      aux_sel_q <= ctrl_q[MAS_CTRL_AUXSEL_LO +: 2];
      if (ctrl_q[MAS_CTRL_FULL]) begin
        adc_chan_q <= MAS_CH_U;
        last_chan_q <= ctrl_q[MAS_CTRL_AUXEN] ? MAS_CH_AUX : MAS_CH_W;
      end else begin
        adc_chan_q <= MAS_CH_V;
        last_chan_q <= MAS_CH_W;
      end
    end else if (state_q == MAS_CONVERT && conv_last && adc_chan_q != last_chan_q) begin
      adc_chan_q <= adc_chan_q + 1'b1;
    end
  end

  // hold covers the whole conversion so all channels share one sampling instant
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_hold_q <= 1'b0;
      adc_convert_q <= 1'b0;
    end else begin
      adc_hold_q <= (state_q == MAS_SAMPLE && cnt_q == MAS_CNT_BITS'(MAS_SHA_CYCLES - 1))
                    || (state_q == MAS_CONVERT && !group_done);
      adc_convert_q <= (state_q == MAS_SAMPLE && cnt_q == MAS_CNT_BITS'(MAS_SHA_CYCLES - 1))
                       || (state_q == MAS_CONVERT && conv_last && !group_done);
    end
  end

  // converter result is sampled on the last clock of its 40-clock slot
  for (genvar ch = 0; ch < 4; ch++) begin : g_res
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        result_q[ch] <= '0;
      end else if (state_q == MAS_CONVERT && conv_last && adc_chan_q == 2'(ch)) begin
        result_q[ch] <= {adc_result, 1'b0};
      end
    end
  end

  mas_pwm_sync #(
    .WIDTH(PWM_WIDTH)
  ) u_pwm_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .period(pwm_per_q),
    .sync_pulse_q(pwm_cycle_sync_pulse)
  );

  // open drain: never drives high, only enables the low level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_n_out_q <= 1'b0;
      irq_n_oe_q <= 1'b0;
    end else begin
      irq_n_out_q <= 1'b0;
      irq_n_oe_q <= |(((status_q & ~stat_clr_wr & ~{3{stat_clr_rd}}) | stat_set) & mask_q);
    end
  end
endmodule
`default_nettype wire

// [sim/mas_adc_model.sv]
// converter stand-in: holds one code per channel through each slot
`timescale 1ns/10ps
`default_nettype none
module mas_adc_model
  import mas_pkg::*;
(
  input wire logic hclk,
  input wire logic adc_hold_q,
  input wire logic adc_convert_q,
  input wire logic [1:0] adc_chan_q,
  input wire logic [1:0] aux_sel_q,
  input wire logic [10:0] base,
  output logic [MAS_RES_BITS-1:0] adc_result
);
  initial adc_result = 11'h000;
  // toggles outside a group so a stale sample never matches
  always @(posedge hclk) begin
    if (!adc_hold_q) adc_result <= ~adc_result;
    else if (adc_convert_q) adc_result <= base + {adc_chan_q, aux_sel_q, 7'h00};
  end
endmodule
`default_nettype wire

// [sim/mas_acq_seq_sva.sv]
// concurrent checks on the sequencer ports
`timescale 1ns/10ps
`default_nettype none
module mas_acq_seq_sva
  import mas_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic adc_hold_q,
  input wire logic adc_convert_q,
  input wire logic [1:0] adc_chan_q,
  input wire logic [1:0] aux_sel_q,
  input wire logic pwm_cycle_sync_pulse,
  input wire logic irq_n_out_q
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [6:0] gap_q;
  // idle cycles since last group; saturates so it never wraps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) gap_q <= 7'h00;
    else if (adc_hold_q) gap_q <= 7'h00;
    else if (gap_q != 7'h7f) gap_q <= gap_q + 7'h01;
  end
  sequence s_launch;
    $rose(adc_hold_q) ##[0:1] adc_convert_q;
  endsequence
  // last slot may end one cycle late as hold drops
  sequence s_slot;
    (adc_hold_q && !adc_convert_q)[*8] ##32 (adc_convert_q or (##1 !adc_hold_q));
  endsequence
  a_irq_open_drain: assert property (irq_n_out_q == 1'b0)
    else $error("interrupt pin driven high");
  a_sync_single: assert property (pwm_cycle_sync_pulse |=> !pwm_cycle_sync_pulse)
    else $error("sync pulse longer than one clock");
  a_conv_spacing: assert property (adc_convert_q |=> s_slot)
    else $error("conversion slot not 40 clocks");
  a_chan_steps: assert property (adc_convert_q && $past(adc_convert_q, 40) |-> adc_chan_q == $past(adc_chan_q, 20) + 2'h1)
    else $error("channel order broken");
  a_group_floor: assert property (s_launch |-> ##40 adc_convert_q)
    else $error("group with a single channel");
  a_first_chan: assert property (s_launch |-> adc_chan_q inside {MAS_CH_U, MAS_CH_V})
    else $error("group starts on wrong channel");
  a_reacq_gap: assert property ($rose(adc_hold_q) |-> gap_q >= 7'd39)
    else $error("hold too soon after last group");
  a_aux_steady: assert property (adc_hold_q && $past(adc_hold_q) |-> $stable(aux_sel_q))
    else $error("aux select moved in a group");
  a_conv_in_hold: assert property (adc_convert_q |-> adc_hold_q)
    else $error("conversion outside hold");
endmodule
bind mas_acq_seq mas_acq_seq_sva u_mas_acq_seq_sva (.hclk, .hresetn, .adc_hold_q, .adc_convert_q, .adc_chan_q,
  .aux_sel_q, .pwm_cycle_sync_pulse, .irq_n_out_q);
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench for the acquisition sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench;
  import mas_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, start = 1'b0, dph_rd = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, e;
  logic [1:0] htrans = '0, adc_chan_q, aux_sel_q;
  logic [2:0] hsize = MAS_HSIZE_WORD;
  logic [10:0] base = '0, adc_result;
  logic hreadyout, hresp, adc_hold_q, adc_convert_q, sync, irq_out, irq_oe;
  logic [7:0] modes [5] = '{8'h88, 8'h98, 8'h99, 8'h9a, 8'h9b};
  int n_mismatch = 0, cmp_count = 0, cyc = 0, pc;
  logic [31:0] exp_q [$];
  wire irq_line = irq_oe ? irq_out : 1'b1; // pulled up when released
  always #2.5 hclk = ~hclk;
  mas_acq_seq u_mas_acq_seq (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .conversion_start_pin(start), .adc_result,
    .adc_hold_q, .adc_convert_q, .adc_chan_q, .aux_sel_q, .pwm_cycle_sync_pulse(sync),
    .irq_n_out_q(irq_out), .irq_n_oe_q(irq_oe));
  mas_adc_model u_mas_adc_model (.hclk, .adc_hold_q, .adc_convert_q, .adc_chan_q, .aux_sel_q, .base,
    .adc_result);
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // read data checked at the end of each read data phase
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (dph_rd) begin
      e = exp_q.pop_front();
      `CHK(hrdata, e)
      `CHK(hresp, 1'b0)
    end
    dph_rd <= hsel && htrans[1] && !hwrite && hreadyout;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= MAS_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic go();
    @(posedge hclk);
    base <= 11'($urandom);
    start <= 1'b1;
    repeat (2) @(posedge hclk);
    start <= 1'b0; // held two clocks, above the minimum
  endtask
  task automatic wait_irq();
    int n = 0;
    while (irq_line && n < 400) begin
      @(posedge hclk);
      n++;
    end
    `CHK(irq_line, 1'b0)
  endtask
  function automatic logic [31:0] res(input logic [1:0] ch, input logic [1:0] ax);
    return {20'h0, base + {ch, ax, 7'h00}, 1'b0};
  endfunction
  initial begin
    void'($urandom(53));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(MAS_OFF_CTRL, 32'h0);
    rd(MAS_OFF_MASK, 32'h7);
    rd(MAS_OFF_PWMPER, 32'h800);
    rd(8'h20, 32'h0);
    bus(1'b1, MAS_OFF_CTRL, 32'hff);
    rd(MAS_OFF_CTRL, 32'h9b);
    bus(1'b1, MAS_OFF_CTRL, 32'h80);
    repeat (25) @(posedge hclk);
    go();
    wait_irq();
    rd(MAS_OFF_STAT, 32'h1);
    rd(MAS_OFF_STAT, 32'h0);
    `CHK(irq_line, 1'b1)
    rd(MAS_OFF_RES_V, res(MAS_CH_V, 2'h0));
    rd(MAS_OFF_RES_W, res(MAS_CH_W, 2'h0));
    foreach (modes[i]) begin
      bus(1'b1, MAS_OFF_CTRL, {24'h0, modes[i]});
      repeat (25) @(posedge hclk);
      go();
      wait_irq();
      rd(MAS_OFF_STAT, 32'h1);
      for (int c = (modes[i][4] ? 3 : 0); c >= 0; c--)
        rd(MAS_OFF_RES_U + 8'(4 * c), res(2'(c), modes[i][1:0]));
      for (int c = 0; c < 3; c++)
        rd(MAS_OFF_RES_U + 8'(4 * c), res(2'(c), modes[i][1:0]));
    end
    // only the done flag may interrupt until the mask is written again
    bus(1'b1, MAS_OFF_MASK, 32'h1);
    repeat (25) @(posedge hclk);
    go();
    repeat (30) @(posedge hclk);
    go();
    wait_irq();
    rd(MAS_OFF_STAT, 32'h3);
    go();
    wait_irq();
    rd(MAS_OFF_STAT, 32'h5);
    bus(1'b1, MAS_OFF_MASK, 32'h0);
    repeat (25) @(posedge hclk);
    go();
    // pending start already shows as busy, flags clear
    rd(MAS_OFF_STAT, 32'h100);
    repeat (300) @(posedge hclk);
    `CHK(irq_line, 1'b1)
    bus(1'b1, MAS_OFF_MASK, 32'h7);
    wait_irq();
    bus(1'b1, MAS_OFF_STAT, 32'h1);
    rd(MAS_OFF_STAT, 32'h0);
    `CHK(irq_line, 1'b1)
    bus(1'b1, MAS_OFF_PWMPER, 32'h10);
    pc = 0;
    repeat (64) begin
      @(posedge hclk);
      pc += int'(sync);
    end
    `CHK(pc inside {3, 4}, 1'b1)
    bus(1'b1, MAS_OFF_PWMPER, 32'h0);
    repeat (4) @(posedge hclk);
    pc = 0;
    repeat (64) begin
      @(posedge hclk);
      pc += int'(sync);
    end
    `CHK(pc, 0)
    test_done();
  end
endmodule
`default_nettype wire
